// ---- verilog/wwed_detector.sv ----
// within-window event detector with its Avalon-MM register slave
//
// Chosen here: the Avalon-MM register port.
`timescale 1ns/1ps
module wwed_detector (
	input wire logic clk,
	input wire logic resetn,
	input wire wwed_pkg::wwed_avl_req_t avsReq,
	output wwed_pkg::wwed_avl_rsp_t avsRsp,
	input wire wwed_pkg::wwed_sample_t sampleIn,
	output wwed_pkg::wwed_event_t eventOut
);
	//----------------------------------------------------------------------
	// state
	//----------------------------------------------------------------------
	typedef struct packed {
		logic [7:0] cfgOne;
		logic [7:0] cfgTwo;
		logic [7:0] cfgFour;
		logic [7:0] upper;
		logic [7:0] lower;
		logic [7:0] dbcnt;
		logic [wwed_pkg::AXES-1:0][wwed_pkg::SAMPLE_W-1:0] prev;
		logic [7:0] cnt;
		logic armed;
		logic active;
		logic [wwed_pkg::AXES-1:0] axisFlag;
		wwed_pkg::wwed_avl_rsp_t rsp;
		wwed_pkg::wwed_event_t evt;
	} wwed_state_t;

	wwed_state_t state_reg;
	wwed_state_t state_next;

	localparam wwed_state_t STATE_RESET = '{
		cfgOne: wwed_pkg::RESET_BYTE,
		cfgTwo: wwed_pkg::RESET_BYTE,
		cfgFour: wwed_pkg::RESET_BYTE,
		upper: wwed_pkg::RESET_BYTE,
		lower: wwed_pkg::RESET_BYTE,
		dbcnt: wwed_pkg::RESET_BYTE,
		prev: '0,
		cnt: wwed_pkg::RESET_BYTE,
		armed: 1'b1,
		active: 1'b0,
		axisFlag: '0,
		rsp: '{readdata: '0, waitrequest: 1'b1},
		evt: '0
	};

	//----------------------------------------------------------------------
	// per-axis window comparison
	//----------------------------------------------------------------------
	logic [wwed_pkg::AXES-1:0] insideW;
	logic [wwed_pkg::AXES-1:0] enableW;
	logic relativeMode;
	logic signed [wwed_pkg::SAMPLE_W:0] upperExt;
	logic signed [wwed_pkg::SAMPLE_W:0] lowerExt;

	assign relativeMode = state_reg.cfgTwo[wwed_pkg::C2_RELATIVE_BIT];
	assign upperExt = {state_reg.upper[wwed_pkg::SAMPLE_W-1], state_reg.upper};
	assign lowerExt = {state_reg.lower[wwed_pkg::SAMPLE_W-1], state_reg.lower};

	genvar gi;
	generate
		for (gi = 0; gi < wwed_pkg::AXES; gi++) begin : gAxis
			logic signed [wwed_pkg::SAMPLE_W:0] curExt;
			logic signed [wwed_pkg::SAMPLE_W:0] prevExt;
			logic signed [wwed_pkg::SAMPLE_W:0] measured;
			assign curExt = {sampleIn.value[gi][wwed_pkg::SAMPLE_W-1], sampleIn.value[gi]};
			assign prevExt = {state_reg.prev[gi][wwed_pkg::SAMPLE_W-1], state_reg.prev[gi]};
			// delta of two signed samples always fits one extra bit
			assign measured = relativeMode ? curExt - prevExt : curExt;
			assign insideW[gi] = (measured < upperExt) && (measured > lowerExt);
			assign enableW[gi] = state_reg.cfgOne[wwed_pkg::C1_EN_POS[gi]];

			// independent signed compare of the raw pins, raw mode with refresh on every sample
			chk_axis_inside: assert property (@(posedge clk) disable iff (!resetn)
				sampleIn.strobe && !relativeMode && !state_reg.cfgOne[wwed_pkg::C1_LATCH_BIT] && enableW[gi]
				&& state_reg.dbcnt == wwed_pkg::RESET_BYTE
				&& $signed(sampleIn.value[gi]) < $signed(state_reg.upper)
				&& $signed(sampleIn.value[gi]) > $signed(state_reg.lower)
				|=> state_reg.axisFlag[gi])
				else $error("axis inside the window but its flag is clear");
			chk_axis_outside: assert property (@(posedge clk) disable iff (!resetn)
				sampleIn.strobe && !relativeMode && !state_reg.cfgOne[wwed_pkg::C1_LATCH_BIT]
				&& state_reg.dbcnt == wwed_pkg::RESET_BYTE
				&& ($signed(sampleIn.value[gi]) >= $signed(state_reg.upper)
				|| $signed(sampleIn.value[gi]) <= $signed(state_reg.lower))
				|=> !state_reg.axisFlag[gi])
				else $error("axis on or beyond a threshold but its flag is set");
			chk_axis_masked: assert property (@(posedge clk) disable iff (!resetn)
				!enableW[gi] && !state_reg.axisFlag[gi] |=> !state_reg.axisFlag[gi])
				else $error("disabled axis raised its flag");
		end
	endgenerate

	//----------------------------------------------------------------------
	// combination and debounce
	//----------------------------------------------------------------------
	logic anyInside;
	logic allInside;
	logic condNow;
	logic [7:0] cntInc;
	logic countMet;
	logic latchMode;
	logic [wwed_pkg::AXES-1:0] maskedFlags;

	assign maskedFlags = insideW & enableW;
	assign anyInside = |maskedFlags;
	// empty enable set must not make the all-axes test vacuously true
	assign allInside = (&(insideW | ~enableW)) & (|enableW);
	assign condNow = state_reg.cfgTwo[wwed_pkg::C2_ALL_BIT] ? allInside : anyInside;
	assign cntInc = (state_reg.cnt == wwed_pkg::CNT_MAX) ? state_reg.cnt : state_reg.cnt + wwed_pkg::CNT_ONE;
	assign countMet = condNow && (cntInc >= state_reg.dbcnt);
	assign latchMode = state_reg.cfgOne[wwed_pkg::C1_LATCH_BIT];

	//----------------------------------------------------------------------
	// bus decode
	//----------------------------------------------------------------------
	logic busReq;
	logic busAccept;
	logic busDone;
	logic statusRead;
	logic [7:0] statusByte;
	logic [7:0] readByte;

	assign busReq = avsReq.read | avsReq.write;
	// one wait cycle: waitrequest drops the cycle after a request is seen
	assign busAccept = busReq & state_reg.rsp.waitrequest;
	assign busDone = busReq & ~state_reg.rsp.waitrequest;
	// clear on the accept edge, which also loads readdata: a sample landing in between cannot be lost
	assign statusRead = busAccept & avsReq.read & (avsReq.address == wwed_pkg::IDX_STATUS);

	always_comb begin
		statusByte = wwed_pkg::RESET_BYTE;
		statusByte[wwed_pkg::ST_ACTIVE_BIT] = state_reg.active;
		for (int i = 0; i < wwed_pkg::AXES; i++) begin
			statusByte[wwed_pkg::ST_AXIS_POS[i]] = state_reg.axisFlag[i];
		end
	end

	always_comb begin
		unique case (avsReq.address)
			wwed_pkg::IDX_STATUS: readByte = statusByte;
			wwed_pkg::IDX_CFG_ONE: readByte = state_reg.cfgOne;
			wwed_pkg::IDX_CFG_TWO: readByte = state_reg.cfgTwo;
			wwed_pkg::IDX_UPPER: readByte = state_reg.upper;
			wwed_pkg::IDX_LOWER: readByte = state_reg.lower;
			wwed_pkg::IDX_DBCNT: readByte = state_reg.dbcnt;
			wwed_pkg::IDX_CFG_FOUR: readByte = state_reg.cfgFour;
			default: readByte = wwed_pkg::RESET_BYTE;
		endcase
	end

	//----------------------------------------------------------------------
	// next state
	//----------------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		state_next.evt.wakeTimerReset = 1'b0;
		state_next.rsp.waitrequest = ~busAccept;
		if (busAccept && avsReq.read) begin
			state_next.rsp.readdata = {{(wwed_pkg::DATA_W-8){1'b0}}, readByte};
		end
		if (busDone && avsReq.write) begin
			unique case (avsReq.address)
				wwed_pkg::IDX_CFG_ONE: state_next.cfgOne = avsReq.writedata[7:0];
				wwed_pkg::IDX_CFG_TWO: state_next.cfgTwo = avsReq.writedata[7:0];
				wwed_pkg::IDX_UPPER: state_next.upper = avsReq.writedata[7:0];
				wwed_pkg::IDX_LOWER: state_next.lower = avsReq.writedata[7:0];
				wwed_pkg::IDX_DBCNT: state_next.dbcnt = avsReq.writedata[7:0];
				wwed_pkg::IDX_CFG_FOUR: state_next.cfgFour = avsReq.writedata[7:0];
				default: ;
			endcase
		end
		// read clears latched results; a set in the same cycle below wins
		if (statusRead && latchMode) begin
			state_next.active = 1'b0;
			state_next.axisFlag = '0;
		end
		if (sampleIn.strobe) begin
			state_next.prev = sampleIn.value;
			state_next.cnt = condNow ? cntInc : wwed_pkg::RESET_BYTE;
			if (state_reg.cfgFour[wwed_pkg::C4_WAKE_BIT] && state_reg.active) begin
				state_next.evt.wakeTimerReset = 1'b1;
			end
			if (latchMode) begin
				if (countMet && state_reg.armed && !state_reg.active) begin
					state_next.active = 1'b1;
					state_next.armed = 1'b0;
					state_next.axisFlag = maskedFlags;
				end
				if (!condNow) begin
					state_next.armed = 1'b1;
				end
			end else begin
				state_next.armed = 1'b1;
				state_next.active = countMet;
				if (countMet || state_reg.dbcnt == wwed_pkg::RESET_BYTE) begin
					state_next.axisFlag = maskedFlags;
				end
			end
		end
		state_next.evt.sleepInhibit = state_next.cfgFour[wwed_pkg::C4_WAKE_BIT] & state_next.active;
		state_next.evt.interruptPinA = state_next.cfgFour[wwed_pkg::C4_ROUTE_A_BIT] & state_next.active;
		state_next.evt.interruptPinB = state_next.cfgFour[wwed_pkg::C4_ROUTE_B_BIT] & state_next.active;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= STATE_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	assign avsRsp = state_reg.rsp;
	assign eventOut = state_reg.evt;

	//----------------------------------------------------------------------
	// checks
	//----------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	sequence s_accept;
		busAccept;
	endsequence

	sequence s_latchedClear;
		statusRead && latchMode && !sampleIn.strobe;
	endsequence

	sequence s_strobe;
		sampleIn.strobe;
	endsequence

	sequence s_quiet;
		!sampleIn.strobe && !statusRead;
	endsequence

	// flags refresh on every sample here, so active can be cross-checked against them
	sequence s_plainRefresh;
		sampleIn.strobe && !latchMode && state_reg.dbcnt == wwed_pkg::RESET_BYTE;
	endsequence

	chk_bus_one_wait: assert property (s_accept |=> !avsRsp.waitrequest ##1 avsRsp.waitrequest)
		else $error("waitrequest not low for exactly one cycle");

	chk_status_layout: assert property (
		s_accept ##0 (avsReq.read && avsReq.address == wwed_pkg::IDX_STATUS)
		|=> avsRsp.readdata[wwed_pkg::ST_ACTIVE_BIT] == $past(state_reg.active) && avsRsp.readdata[6] == 1'b0
		&& avsRsp.readdata[4] == 1'b0 && avsRsp.readdata[0] == 1'b0 && avsRsp.readdata[31:8] == '0)
		else $error("status byte layout wrong");

	chk_read_clears: assert property (s_latchedClear |=> !state_reg.active && state_reg.axisFlag == '0)
		else $error("latched status not cleared by read");

	chk_debounce_met: assert property ($rose(state_reg.active) |->
		$past(sampleIn.strobe) && $past(condNow) && $past(cntInc) >= $past(state_reg.dbcnt))
		else $error("active rose before debounce count reached");

	chk_none_enabled: assert property ($rose(state_reg.active) |-> $past(enableW) != '0)
		else $error("active rose with no axis enabled");

	chk_zero_count_update: assert property (
		sampleIn.strobe && !latchMode && state_reg.dbcnt == wwed_pkg::RESET_BYTE
		|=> state_reg.axisFlag == $past(maskedFlags))
		else $error("axis flags not refreshed with zero debounce");

	chk_latch_holds: assert property (
		latchMode && state_reg.active && !statusRead && !(busDone && avsReq.write) |=> state_reg.active)
		else $error("latched active dropped without a read");

	chk_wake_reset: assert property (
		sampleIn.strobe && state_reg.active && state_reg.cfgFour[wwed_pkg::C4_WAKE_BIT]
		|=> eventOut.wakeTimerReset ##1 !eventOut.wakeTimerReset || $past(sampleIn.strobe))
		else $error("wake timer reset pulse missing");

	chk_sleep_hold: assert property (
		state_reg.active && state_reg.cfgFour[wwed_pkg::C4_WAKE_BIT] |-> eventOut.sleepInhibit)
		else $error("sleep not inhibited while active");

	chk_pin_route: assert property (
		eventOut.interruptPinA == (state_reg.active && state_reg.cfgFour[wwed_pkg::C4_ROUTE_A_BIT])
		&& eventOut.interruptPinB == (state_reg.active && state_reg.cfgFour[wwed_pkg::C4_ROUTE_B_BIT]))
		else $error("interrupt pin routing wrong");

	chk_counter_reset: assert property (sampleIn.strobe && !condNow |=> state_reg.cnt == '0)
		else $error("debounce counter not reset on false condition");

	chk_count_step: assert property (
		s_strobe ##0 (condNow && state_reg.cnt != wwed_pkg::CNT_MAX)
		|=> state_reg.cnt == $past(state_reg.cnt) + wwed_pkg::CNT_ONE)
		else $error("debounce counter did not advance by one");

	chk_count_idle: assert property (!sampleIn.strobe |=> $stable(state_reg.cnt))
		else $error("debounce counter moved between samples");

	chk_hold_between: assert property (
		s_quiet |=> $stable(state_reg.active) && $stable(state_reg.axisFlag))
		else $error("status changed with no sample and no read");

	chk_unlatched_read: assert property (
		statusRead && !latchMode && !sampleIn.strobe |=> $stable(state_reg.active) && $stable(state_reg.axisFlag))
		else $error("unlatched status changed by a read");

	chk_active_reach: assert property (
		s_strobe ##0 (!latchMode && condNow && state_reg.cnt >= state_reg.dbcnt) |=> state_reg.active)
		else $error("active not set after the debounce count");

	chk_active_drop: assert property (
		s_strobe ##0 (!latchMode && !condNow) |=> !state_reg.active)
		else $error("unlatched active kept after the condition ended");

	chk_flag_hold: assert property (
		s_strobe ##0 (!latchMode && !countMet && state_reg.dbcnt != wwed_pkg::RESET_BYTE)
		|=> $stable(state_reg.axisFlag))
		else $error("axis flags moved before the debounce count");

	chk_flag_refresh: assert property (
		s_strobe ##0 (!latchMode && countMet) |=> state_reg.axisFlag == $past(maskedFlags))
		else $error("axis flags not refreshed with active set");

	chk_combine_any: assert property (
		s_plainRefresh ##0 !state_reg.cfgTwo[wwed_pkg::C2_ALL_BIT]
		|=> state_reg.active == (|state_reg.axisFlag))
		else $error("any-axis combine disagrees with the axis flags");

	chk_combine_all: assert property (
		s_plainRefresh ##0 state_reg.cfgTwo[wwed_pkg::C2_ALL_BIT]
		|=> state_reg.active == (state_reg.axisFlag == $past(enableW) && $past(enableW) != '0))
		else $error("all-axes combine disagrees with the axis flags");

	chk_wake_quiet: assert property (
		!(sampleIn.strobe && state_reg.active && state_reg.cfgFour[wwed_pkg::C4_WAKE_BIT])
		|=> !eventOut.wakeTimerReset)
		else $error("wake timer reset without an active sample");

	chk_armed_block: assert property (
		latchMode && !state_reg.armed |=> !$rose(state_reg.active))
		else $error("latched active rose again without a false condition");

	chk_rearm_on_false: assert property (
		s_strobe ##0 (latchMode && !condNow) |=> state_reg.armed)
		else $error("detector not re-armed by a false condition");
endmodule

// ---- verilog/wwed_pkg.sv ----
// package of constants and carrier types for the within-window event detector
//----------------------------------------------------------------------
// Overview of operation
// - Active flag rises only after the condition held debounce-count consecutive samples.
// - Active flag sits at status bit 7; without latch, reads zero when nothing inside.
// - Enabled axes combine by all-axes or any-axis, chosen by config two.
// - Axis inside flag is one when strictly between lower and upper thresholds.
// - Axis flags at status bits 5, 3, 1; other bits zero, read-only.
// - Axis flag only means anything while its axis enable is one.
// - No axis enabled means no within-window event is ever raised.
// - Absolute mode compares raw samples; relative mode compares sample-to-sample change.
// - Wake enabled and active set resets the wake/sleep timer every sample.
// - With wake enabled, no automatic sleep until the active flag clears.
// - Latch mode captures axis flags when active rises; status read clears them.
// - Without latch, axis flags update when active is set and count reached.
// - Without latch and zero debounce count, axis flags update every sample.
// - Active flag can be routed to either interrupt pin.
// - Latch mode asserts active only on false-to-true change of the condition.
// - Without latch, axis flags follow in real time and may clear unread.
// - Axis takes part only when its enable bit in config one is one.
//----------------------------------------------------------------------
package wwed_pkg;
	localparam int AXES = 3;
	localparam int SAMPLE_W = 8;
	localparam int ADDR_W = 6;
	localparam int DATA_W = 32;

	// register indexes; byte address is four times the index
	localparam logic [ADDR_W-1:0] IDX_STATUS = 6'h2E;
	localparam logic [ADDR_W-1:0] IDX_CFG_ONE = 6'h2F;
	localparam logic [ADDR_W-1:0] IDX_CFG_TWO = 6'h30;
	localparam logic [ADDR_W-1:0] IDX_UPPER = 6'h31;
	localparam logic [ADDR_W-1:0] IDX_LOWER = 6'h32;
	localparam logic [ADDR_W-1:0] IDX_DBCNT = 6'h33;
	localparam logic [ADDR_W-1:0] IDX_CFG_FOUR = 6'h34;

	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [7:0] CNT_MAX = 8'hFF;
	localparam logic [7:0] CNT_ONE = 8'h01;

	// status layout
	localparam int ST_ACTIVE_BIT = 7;
	localparam int ST_AXIS_POS [AXES] = '{5, 3, 1};
	// config one layout
	localparam int C1_LATCH_BIT = 6;
	localparam int C1_EN_POS [AXES] = '{2, 1, 0};
	// config two layout
	localparam int C2_ALL_BIT = 0;
	localparam int C2_RELATIVE_BIT = 1;
	// config four layout
	localparam int C4_WAKE_BIT = 0;
	localparam int C4_ROUTE_A_BIT = 1;
	localparam int C4_ROUTE_B_BIT = 2;

	typedef struct packed {
		logic read;
		logic write;
		logic [ADDR_W-1:0] address;
		logic [DATA_W-1:0] writedata;
	} wwed_avl_req_t;

	typedef struct packed {
		logic [DATA_W-1:0] readdata;
		logic waitrequest;
	} wwed_avl_rsp_t;

	typedef struct packed {
		logic strobe;
		logic [AXES-1:0][SAMPLE_W-1:0] value;
	} wwed_sample_t;

	typedef struct packed {
		logic interruptPinA;
		logic interruptPinB;
		logic wakeTimerReset;
		logic sleepInhibit;
	} wwed_event_t;
endpackage

// ---- testbench/wwed_sample_src.sv ----
// sensor front end model feeding samples to the detector
`timescale 1ns/1ps
module wwed_sample_src (
	input wire logic clk,
	output wwed_pkg::wwed_sample_t sampleOut
);
	initial begin
		sampleOut = '0;
	end

	//----------------------------------------------------------------------
	// one sample period
	//----------------------------------------------------------------------
	// strobe is one cycle wide; between strobes the bus shows the inverse so nothing stale is sampled
	task automatic send(input logic [7:0] x, input logic [7:0] y, input logic [7:0] z);
		@(posedge clk);
		sampleOut <= '{strobe: 1'b1, value: {z, y, x}};
		@(posedge clk);
		sampleOut <= '{strobe: 1'b0, value: ~{z, y, x}};
	endtask
endmodule

// ---- testbench/tb_wwed_detector.sv ----
// self-checking bench for the within-window event detector
`timescale 1ns/1ps
module tb_wwed_detector;
	logic clk;
	logic resetn;
	wwed_pkg::wwed_avl_req_t avsReq;
	wwed_pkg::wwed_avl_rsp_t avsRsp;
	wwed_pkg::wwed_sample_t sampleIn;
	wwed_pkg::wwed_event_t eventOut;
	int badCount = 0;
	int samplesChecked = 0;

	wwed_detector wwed_detector_inst (.clk(clk), .resetn(resetn), .avsReq(avsReq), .avsRsp(avsRsp),
		.sampleIn(sampleIn), .eventOut(eventOut));
	wwed_sample_src wwed_sample_src_inst (.clk(clk), .sampleOut(sampleIn));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	//----------------------------------------------------------------------
	// bus and compare tasks
	//----------------------------------------------------------------------
	task automatic busOp(input logic rd, input logic [5:0] addr, input logic [7:0] wd, output logic [31:0] d);
		@(posedge clk);
		avsReq <= '{read: rd, write: ~rd, address: addr, writedata: {24'h000000, wd}};
		do @(posedge clk); while (avsRsp.waitrequest !== 1'b0);
		d = avsRsp.readdata;
		avsReq <= '0;
	endtask

	task automatic wr(input logic [5:0] addr, input logic [7:0] wd);
		logic [31:0] d;
		busOp(1'b0, addr, wd, d);
	endtask

	task automatic chkReg(input logic [5:0] addr, input logic [7:0] exp);
		logic [31:0] d;
		busOp(1'b1, addr, 8'h00, d);
		samplesChecked++;
		if (d !== {24'h000000, exp}) begin
			badCount++;
			$display("Error at %0t: register %h read %h, expected %h", $time, addr, d, exp);
		end
	endtask

	task automatic chkBit(input logic got, input logic exp, input string what);
		samplesChecked++;
		if (got !== exp) begin
			badCount++;
			$display("Error at %0t: %s is %b, expected %b", $time, what, got, exp);
		end
	endtask

	task automatic send(input logic [7:0] x, input logic [7:0] y, input logic [7:0] z);
		wwed_sample_src_inst.send(x, y, z);
		@(negedge clk);
	endtask

	task automatic closeOut;
		if (badCount == 0 && samplesChecked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// whole run is under two hundred cycles; this only cuts a hang
	initial begin
		repeat (20000) @(posedge clk);
		badCount++;
		closeOut();
	end

	//----------------------------------------------------------------------
	// tests
	//----------------------------------------------------------------------
	initial begin
		resetn = 1'b0;
		avsReq = '0;
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		chkReg(6'h2E, 8'h00);
		wr(6'h2E, 8'hFF);
		chkReg(6'h2E, 8'h00);
		chkReg(6'h10, 8'h00);
		// window is -10 < v < 10
		wr(6'h31, 8'h0A);
		wr(6'h32, 8'hF6);
		wr(6'h2F, 8'h07);
		wr(6'h30, 8'h00);
		wr(6'h33, 8'h02);
		wr(6'h34, 8'h03);
		send(8'h05, 8'h32, 8'h32);
		chkReg(6'h2E, 8'h00);
		send(8'h05, 8'h32, 8'h32);
		chkBit(eventOut.interruptPinA, 1'b1, "pin A");
		chkBit(eventOut.interruptPinB, 1'b0, "pin B");
		chkBit(eventOut.sleepInhibit, 1'b1, "sleep inhibit");
		chkReg(6'h2E, 8'hA0);
		// thresholds themselves lie outside the window
		send(8'h0A, 8'hF6, 8'h09);
		chkBit(eventOut.wakeTimerReset, 1'b1, "wake timer reset");
		chkReg(6'h2E, 8'h82);
		send(8'h32, 8'h32, 8'h32);
		chkBit(eventOut.interruptPinA, 1'b0, "pin A");
		chkBit(eventOut.sleepInhibit, 1'b0, "sleep inhibit");
		chkReg(6'h2E, 8'h02);
		// all-axes combine with zero debounce
		wr(6'h30, 8'h01);
		wr(6'h33, 8'h00);
		send(8'h05, 8'h05, 8'h32);
		chkReg(6'h2E, 8'h28);
		send(8'h05, 8'h05, 8'h05);
		chkReg(6'h2E, 8'hAA);
		wr(6'h2F, 8'h04);
		send(8'h32, 8'h05, 8'h05);
		chkReg(6'h2E, 8'h00);
		send(8'h05, 8'h32, 8'h32);
		chkReg(6'h2E, 8'hA0);
		wr(6'h2F, 8'h00);
		send(8'h00, 8'h00, 8'h00);
		chkBit(eventOut.interruptPinA, 1'b0, "pin A");
		chkReg(6'h2E, 8'h00);
		// relative mode: raw values are all outside, deltas 5, 20, 0
		wr(6'h2F, 8'h07);
		wr(6'h30, 8'h02);
		send(8'h64, 8'h64, 8'h64);
		send(8'h69, 8'h78, 8'h64);
		chkReg(6'h2E, 8'hA2);
		// latched mode, routed to pin B
		wr(6'h2F, 8'h47);
		wr(6'h30, 8'h00);
		wr(6'h33, 8'h01);
		wr(6'h34, 8'h04);
		send(8'h32, 8'h32, 8'h32);
		chkReg(6'h2E, 8'hA2);
		send(8'h05, 8'h32, 8'h32);
		chkBit(eventOut.interruptPinB, 1'b1, "pin B");
		chkBit(eventOut.interruptPinA, 1'b0, "pin A");
		send(8'h32, 8'h32, 8'h32);
		chkReg(6'h2E, 8'hA0);
		chkReg(6'h2E, 8'h00);
		send(8'h05, 8'h32, 8'h32);
		chkReg(6'h2E, 8'hA0);
		send(8'h05, 8'h32, 8'h32);
		chkReg(6'h2E, 8'h00);
		send(8'h32, 8'h32, 8'h32);
		send(8'h05, 8'h32, 8'h32);
		chkReg(6'h2E, 8'hA0);
		closeOut();
	end
endmodule
